// [ixa_defines.vh]
// Purpose: Shared constants for the index address adder block
// Assumes: 32-bit AXI4-Lite register bus, 15-bit adder datapath
// Notes:   Bit 0 of every 15-bit vector is adder position 17, bit 14 is position 3
`ifndef IXA_DEFINES_VH
`define IXA_DEFINES_VH
// ----------------------------------------
// Datapath geometry
// ----------------------------------------
`define IXA_W          15
`define IXA_GRP        5
`define IXA_TOP        14
`define IXA_NEXT       13
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IXA_OFF_CMD    8'h00
`define IXA_OFF_PROG   8'h04
`define IXA_OFF_ADDR   8'h08
`define IXA_OFF_BKUP   8'h0c
`define IXA_OFF_SRADR  8'h10
`define IXA_OFF_SRDEC  8'h14
`define IXA_OFF_SC     8'h18
`define IXA_OFF_TAG    8'h1c
`define IXA_OFF_XR1    8'h20
`define IXA_OFF_XR2    8'h24
`define IXA_OFF_XR4    8'h28
`define IXA_OFF_MODE   8'h2c
`define IXA_OFF_STAT   8'h30
`define IXA_OFF_LATCH  8'h34
`define IXA_OFF_OVL    8'h38
// ----------------------------------------
// Command fields, operations, sources, destinations
// ----------------------------------------
`define IXA_CMD_OP     2:0
`define IXA_CMD_SRC    6:4
`define IXA_CMD_DST    11:8
`define IXA_CMD_BITS   12
`define IXA_OP_ADDMOD  3'h0
`define IXA_OP_INC     3'h1
`define IXA_OP_DEC     3'h2
`define IXA_OP_PASS    3'h3
`define IXA_OP_XTEST   3'h4
`define IXA_OP_CONV    3'h5
`define IXA_DST_NONE   4'h0
`define IXA_DST_INDEX  4'h1
`define IXA_DST_PROG   4'h2
`define IXA_DST_ADDR   4'h3
`define IXA_DST_BKUP   4'h4
`define IXA_DST_SRDEC  4'h5
`define IXA_DST_SRADR  4'h6
`define IXA_DST_SC     4'h7
`define IXA_DST_OVL    4'h8
// ----------------------------------------
// Mode, status and bus response codes
// ----------------------------------------
`define IXA_MODE_COMPAT 0
`define IXA_MODE_BIGMEM 1
`define IXA_RESP_OKAY  2'h0
`define IXA_RESP_SLVERR 2'h2
`endif

// [ixa_gates.v]
// Purpose: Operand gating for the index adder (A six-way select, B terms, carry)
// Assumes: Controller enables at most one A source and one B source at a time
// Notes:   Purely combinational
`timescale 1ns/100ps
`include "ixa_defines.vh"
module ixa_gates #(
  parameter W = `IXA_W
) (
  // Control
  input  wire         gate,
  input  wire [2:0]   op,
  input  wire [2:0]   src,
  input  wire         tag_zero,
  // Source registers
  input  wire [W-1:0] prog_cnt,
  input  wire [W-1:0] addr_reg,
  input  wire [W-1:0] backup,
  input  wire [W-1:0] sradr,
  input  wire [W-1:0] srdec,
  input  wire [W-1:0] index_sel,
  input  wire [W-1:0] sc,
  // Adder operands
  output wire [W-1:0] a_in,
  output reg  [W-1:0] b_data,
  output reg  [W-1:0] b_force,
  output reg          cin
);
  wire [5:0] src_hot = gate ? (6'h01 << src) : 6'h00;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_asel
      wire [5:0] v = {index_sel[i], srdec[i], sradr[i], backup[i], addr_reg[i], prog_cnt[i]};
      assign a_in[i] = |(v & src_hot);
    end
  endgenerate

  always @* begin
    b_data  = {W{1'b0}};
    b_force = {W{1'b0}};
    cin     = 1'b0;
    if (gate) begin
      case (op)
        `IXA_OP_ADDMOD: begin
          cin = 1'b1;
          if (tag_zero) begin
            b_force = {W{1'b1}};
          end else begin
            b_data = ~index_sel;
          end
        end
        `IXA_OP_INC:   b_force = {{(W-1){1'b0}}, 1'b1};
        `IXA_OP_DEC:   b_force = {W{1'b1}};
        `IXA_OP_XTEST: begin
          b_data = ~index_sel;
          cin    = 1'b1;
        end
        `IXA_OP_CONV:  b_data = sc;
        default:       b_data = {W{1'b0}};
      endcase
    end
  end
endmodule // ixa_gates

// [ixa_adder.v]
// Purpose: 15-position index adder, three 5-position lookahead groups
// Assumes: Only one B term is active at a time
// Notes:   Group carries are flat sums of products, no ripple between groups
`timescale 1ns/100ps
`include "ixa_defines.vh"
module ixa_adder #(
  parameter W = `IXA_W,
  parameter G = `IXA_GRP
) (
  // Operands
  input  wire [W-1:0] a,
  input  wire [W-1:0] b_data,
  input  wire [W-1:0] b_force,
  input  wire         cin,
  // Mode
  input  wire         compat,
  input  wire         bigmem,
  // Result
  output wire [W-1:0] sum,
  output wire         carry3
);
  wire [W-1:0] b = b_data | b_force;
  wire [W-1:0] g = a & b;
  wire [W-1:0] blk = {compat, compat & bigmem, {(W-2){1'b0}}};
  wire [W-1:0] p = a | b_data | b_force | blk;
  wire [2:0] gg;
  wire [2:0] gp;
  wire [2:0] gc;
  wire [W-1:0] c;

  // Carry into each bit of a group from that group's own inputs and its carry-in ci
  function [G-1:0] grp_carry(input [G-1:0] gi, input [G-1:0] pi, input ci);
    integer k;
    integer j;
    reg acc;
    reg pr;
    begin
      for (k = 0; k < G; k = k + 1) begin
        pr  = ci;
        acc = 1'b0;
        for (j = 0; j < k; j = j + 1) begin
          acc = (acc & pi[j]) | gi[j];
          pr  = pr & pi[j];
        end
        grp_carry[k] = acc | pr;
      end
    end
  endfunction

  genvar n;
  generate
    for (n = 0; n < 3; n = n + 1) begin : g_grp
      wire [G-1:0] gs = g[n*G +: G];
      wire [G-1:0] ps = p[n*G +: G];
      wire [G-1:0] ct = grp_carry(gs, ps, 1'b0);
      assign gp[n] = &ps;
      assign gg[n] = gs[G-1] | (ps[G-1] & ct[G-1]);
      assign c[n*G +: G] = grp_carry(gs, ps, gc[n]);
    end
  endgenerate

  assign gc[0] = cin;
  assign gc[1] = gg[0] | (gp[0] & cin);
  assign gc[2] = gg[1] | (gp[1] & gg[0]) | (gp[1] & gp[0] & cin);
  assign carry3 = gg[2] | (gp[2] & gg[1]) | (gp[2] & gp[1] & gg[0])
                | (gp[2] & gp[1] & gp[0] & cin);
  assign sum = ((a ^ b) ^ c) & ~blk;
endmodule // ixa_adder

// [ixa_index_adder.v]
// Purpose: Index adder unit with holding latch, destination triggers, AXI4-Lite
// Assumes: Single clock aclk, synchronous active-low reset aresetn
// Notes:   A command write gates operands one cycle later; the latch copies
//          the sum every edge and the destination loads on the edge after.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ixa_defines.vh"
module ixa_index_adder #(
  parameter AW = 8,
  parameter W  = `IXA_W
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite write address
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read address
  input  wire [AW-1:0] s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Second memory address toward the even/odd switch
  output reg  [W-1:0]  memory_addr_switch_addr,
  output reg           memory_addr_switch_valid
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [AW-1:0] awaddr_r;
  reg          aw_got_r;
  reg [31:0]   wdata_r;
  reg [3:0]    wstrb_r;
  reg          w_got_r;
  reg [W-1:0]  program_counter_r;
  reg [W-1:0]  address_register_r;
  reg [W-1:0]  instruction_backup_reg_r;
  reg [W-1:0]  storage_register_adr_r;
  reg [W-1:0]  storage_register_dec_r;
  reg [W-1:0]  shift_counter_r;
  reg [2:0]    tag_r;
  reg [W-1:0]  index_reg1_r;
  reg [W-1:0]  index_reg2_r;
  reg [W-1:0]  index_reg4_r;
  reg [1:0]    mode_r;
  reg [`IXA_CMD_BITS-1:0] cmd_r;
  reg          gate_r;
  reg [W-1:0]  index_sum_holding_latch_r;
  reg          carry3_r;
  reg [3:0]    trig_r;
  reg [3:0]    pend_r;
  reg [31:0]   rd_data;
  reg          rd_ok;
  reg          wr_ok;
  reg [3:0]    trig_nxt;
  reg [3:0]    pend_nxt;

  wire         wr_en = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire [W-1:0] index_sel = ({W{tag_r[0]}} & index_reg1_r)
                         | ({W{tag_r[1]}} & index_reg2_r)
                         | ({W{tag_r[2]}} & index_reg4_r);
  wire [3:0]   dst = cmd_r[`IXA_CMD_DST];
  wire [W-1:0] a_in;
  wire [W-1:0] b_data;
  wire [W-1:0] b_force;
  wire         cin;
  wire [W-1:0] sum;
  wire         carry3;

  // Byte lanes of a write; lanes whose strobe is low keep the old bits
  wire [31:0]  wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0]  wr_bits = wdata_r & wr_mask;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  // Command register holds one source and one B term per pass
  ixa_gates #(
    .W (W)
  ) u_gates (
    .gate     (gate_r),
    .op       (cmd_r[`IXA_CMD_OP]),
    .src      (cmd_r[`IXA_CMD_SRC]),
    .tag_zero (tag_r == 3'h0),
    .prog_cnt (program_counter_r),
    .addr_reg (address_register_r),
    .backup   (instruction_backup_reg_r),
    .sradr    (storage_register_adr_r),
    .srdec    (storage_register_dec_r),
    .index_sel (index_sel),
    .sc       (shift_counter_r),
    .a_in     (a_in),
    .b_data   (b_data),
    .b_force  (b_force),
    .cin      (cin)
  );

  ixa_adder #(
    .W (W)
  ) u_index_adder (
    .a       (a_in),
    .b_data  (b_data),
    .b_force (b_force),
    .cin     (cin),
    .compat  (mode_r[`IXA_MODE_COMPAT]),
    .bigmem  (mode_r[`IXA_MODE_BIGMEM]),
    .sum     (sum),
    .carry3  (carry3)
  );

  // Destination decode: triggers for trigger-built registers, codes for direct paths
  always @* begin
    trig_nxt = 4'h0;
    pend_nxt = `IXA_DST_NONE;
    if (gate_r) begin
      case (dst)
        `IXA_DST_INDEX: trig_nxt = 4'h1;
        `IXA_DST_PROG:  trig_nxt = 4'h2;
        `IXA_DST_ADDR:  trig_nxt = 4'h4;
        `IXA_DST_BKUP:  trig_nxt = 4'h8;
        default:      pend_nxt = dst;
      endcase
    end
  end

  // ----------------------------------------
  // Latch, triggers and register file
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      index_sum_holding_latch_r <= {W{1'b0}};
      carry3_r                  <= 1'b0;
      trig_r                    <= 4'h0;
      pend_r                    <= `IXA_DST_NONE;
      gate_r                    <= 1'b0;
      cmd_r                     <= {`IXA_CMD_BITS{1'b0}};
      program_counter_r         <= {W{1'b0}};
      address_register_r        <= {W{1'b0}};
      instruction_backup_reg_r  <= {W{1'b0}};
      storage_register_adr_r    <= {W{1'b0}};
      storage_register_dec_r    <= {W{1'b0}};
      shift_counter_r           <= {W{1'b0}};
      tag_r                     <= 3'h0;
      index_reg1_r              <= {W{1'b0}};
      index_reg2_r              <= {W{1'b0}};
      index_reg4_r              <= {W{1'b0}};
      mode_r                    <= 2'h0;
      memory_addr_switch_addr   <= {W{1'b0}};
      memory_addr_switch_valid  <= 1'b0;
    end else begin
      // Free-running copy; no enable so back-to-back passes stay in step
      index_sum_holding_latch_r <= sum;
      carry3_r                  <= carry3;
      trig_r                    <= trig_nxt;
      pend_r                    <= pend_nxt;
      gate_r                    <= 1'b0;
      memory_addr_switch_valid  <= 1'b0;
      // Gating line is gone by now, so the triggers pick the receiver
      if (trig_r[0]) begin
        if (tag_r[0]) index_reg1_r <= index_sum_holding_latch_r;
        if (tag_r[1]) index_reg2_r <= index_sum_holding_latch_r;
        if (tag_r[2]) index_reg4_r <= index_sum_holding_latch_r;
      end
      if (trig_r[1]) program_counter_r <= index_sum_holding_latch_r;
      if (trig_r[2]) address_register_r <= index_sum_holding_latch_r;
      if (trig_r[3]) instruction_backup_reg_r <= index_sum_holding_latch_r;
      case (pend_r)
        `IXA_DST_SRDEC: storage_register_dec_r <= index_sum_holding_latch_r;
        `IXA_DST_SRADR: storage_register_adr_r <= index_sum_holding_latch_r;
        `IXA_DST_SC:    shift_counter_r <= index_sum_holding_latch_r;
        `IXA_DST_OVL: begin
          memory_addr_switch_addr  <= index_sum_holding_latch_r;
          memory_addr_switch_valid <= 1'b1;
        end
        default: ;
      endcase
      // Software write last, so it wins over a hardware load in the same cycle
      if (wr_en) begin
        case (awaddr_r)
          `IXA_OFF_CMD: begin
            cmd_r  <= (cmd_r & ~wr_mask[`IXA_CMD_BITS-1:0])
                      | wr_bits[`IXA_CMD_BITS-1:0];
            gate_r <= 1'b1;
          end
          `IXA_OFF_PROG:
            program_counter_r <= (program_counter_r & ~wr_mask[W-1:0])
                                 | wr_bits[W-1:0];
          `IXA_OFF_ADDR:
            address_register_r <= (address_register_r & ~wr_mask[W-1:0])
                                  | wr_bits[W-1:0];
          `IXA_OFF_BKUP:
            instruction_backup_reg_r <= (instruction_backup_reg_r & ~wr_mask[W-1:0])
                                        | wr_bits[W-1:0];
          `IXA_OFF_SRADR:
            storage_register_adr_r <= (storage_register_adr_r & ~wr_mask[W-1:0])
                                      | wr_bits[W-1:0];
          `IXA_OFF_SRDEC:
            storage_register_dec_r <= (storage_register_dec_r & ~wr_mask[W-1:0])
                                      | wr_bits[W-1:0];
          `IXA_OFF_SC:
            shift_counter_r <= (shift_counter_r & ~wr_mask[W-1:0])
                               | wr_bits[W-1:0];
          `IXA_OFF_TAG:
            tag_r <= (tag_r & ~wr_mask[2:0]) | wr_bits[2:0];
          `IXA_OFF_XR1:
            index_reg1_r <= (index_reg1_r & ~wr_mask[W-1:0]) | wr_bits[W-1:0];
          `IXA_OFF_XR2:
            index_reg2_r <= (index_reg2_r & ~wr_mask[W-1:0]) | wr_bits[W-1:0];
          `IXA_OFF_XR4:
            index_reg4_r <= (index_reg4_r & ~wr_mask[W-1:0]) | wr_bits[W-1:0];
          `IXA_OFF_MODE:
            mode_r <= (mode_r & ~wr_mask[1:0]) | wr_bits[1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Write channel slave
  // ----------------------------------------
  always @* begin
    case (awaddr_r)
      `IXA_OFF_CMD, `IXA_OFF_PROG, `IXA_OFF_ADDR, `IXA_OFF_BKUP,
      `IXA_OFF_SRADR, `IXA_OFF_SRDEC, `IXA_OFF_SC, `IXA_OFF_TAG,
      `IXA_OFF_XR1, `IXA_OFF_XR2, `IXA_OFF_XR4, `IXA_OFF_MODE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IXA_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= {AW{1'b0}};
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_en) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `IXA_RESP_OKAY : `IXA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read channel slave
  // ----------------------------------------
  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h00000000;
    case (s_axi_araddr)
      `IXA_OFF_CMD:   rd_data = {20'h00000, cmd_r};
      `IXA_OFF_PROG:  rd_data = {17'h00000, program_counter_r};
      `IXA_OFF_ADDR:  rd_data = {17'h00000, address_register_r};
      `IXA_OFF_BKUP:  rd_data = {17'h00000, instruction_backup_reg_r};
      `IXA_OFF_SRADR: rd_data = {17'h00000, storage_register_adr_r};
      `IXA_OFF_SRDEC: rd_data = {17'h00000, storage_register_dec_r};
      `IXA_OFF_SC:    rd_data = {17'h00000, shift_counter_r};
      `IXA_OFF_TAG:   rd_data = {29'h00000000, tag_r};
      `IXA_OFF_XR1:   rd_data = {17'h00000, index_reg1_r};
      `IXA_OFF_XR2:   rd_data = {17'h00000, index_reg2_r};
      `IXA_OFF_XR4:   rd_data = {17'h00000, index_reg4_r};
      `IXA_OFF_MODE:  rd_data = {30'h00000000, mode_r};
      `IXA_OFF_STAT:  rd_data = {22'h000000, pend_r, trig_r,
                                 gate_r | (|trig_r) | (|pend_r), carry3_r};
      `IXA_OFF_LATCH: rd_data = {17'h00000, index_sum_holding_latch_r};
      `IXA_OFF_OVL:   rd_data = {17'h00000, memory_addr_switch_addr};
      default:        rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IXA_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `IXA_RESP_OKAY : `IXA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // ixa_index_adder

// [ixa_switch_model.sv]
// Purpose: Even/odd memory switch fed by the overlap address
// Assumes: One valid pulse per new address
// Notes:   Keeps the last address it took
`timescale 1ns/100ps
module ixa_switch_model (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Overlap address
  input  wire [14:0] addr,
  input  wire        valid,
  // Captured address
  output reg  [14:0] seen_r
);
  always @(posedge aclk) begin
    if (!aresetn)
      seen_r <= 15'h0;
    else if (valid)
      seen_r <= addr;
  end
endmodule // ixa_switch_model

// [ixa_chk.sv]
// Purpose: Port assertions for the index adder unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the unit
`timescale 1ns/100ps
module ixa_chk #(
  parameter W = 15
) (
  // Clock and reset
  input wire         aclk,
  input wire         aresetn,
  // Bus handshakes
  input wire         s_axi_awvalid,
  input wire         s_axi_awready,
  input wire [1:0]   s_axi_bresp,
  input wire         s_axi_bvalid,
  input wire         s_axi_bready,
  input wire         s_axi_arvalid,
  input wire         s_axi_arready,
  input wire [31:0]  s_axi_rdata,
  input wire         s_axi_rvalid,
  input wire         s_axi_rready,
  // Overlap address
  input wire [W-1:0] memory_addr_switch_addr,
  input wire         memory_addr_switch_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ovl_pulse: assert property (memory_addr_switch_valid |=> !memory_addr_switch_valid)
    else $error("overlap valid longer than one cycle");
  a_ovl_hold: assert property (!memory_addr_switch_valid |-> $stable(memory_addr_switch_addr))
    else $error("overlap address moved without valid");
  a_ovl_cause: assert property (memory_addr_switch_valid |-> $past(s_axi_bvalid, 2))
    else $error("overlap valid without command write");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during read data");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_close: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address still open");
  a_b_answer: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
    else $error("write channel not reopened");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_ovl: cover property (memory_addr_switch_valid);
endmodule // ixa_chk
bind ixa_index_adder ixa_chk #(.W(W)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .memory_addr_switch_addr(memory_addr_switch_addr),
  .memory_addr_switch_valid(memory_addr_switch_valid));

// [ixa_index_adder_test.sv]
// Purpose: Self-checking bench for the index adder unit
// Assumes: AXI4-Lite master tasks, 10 MHz clock
// Notes:   Expected sums are worked out here as 15-bit integers
`timescale 1ns/100ps
module ixa_index_adder_test;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h0, araddr = 8'h0;
  reg  [31:0] wdata = 32'h0, rd;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [1:0]  rs;
  wire        awready, wready, bvalid, arready, rvalid, mvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [14:0] maddr, seen;
  integer     fail_count = 0, compares = 0, cyc = 0, seed = 32'h0c4d5011, i, k, t, v, x;
  always #50 aclk = ~aclk;
  ixa_index_adder DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .memory_addr_switch_addr(maddr), .memory_addr_switch_valid(mvalid));
  ixa_switch_model u_sw (.aclk(aclk), .aresetn(aresetn), .addr(maddr), .valid(mvalid),
    .seen_r(seen));
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
    end
  endtask
  // Trailing edge keeps a following call from reassigning in the same step
  task wr(input [7:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rdw(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  function [11:0] cm(input [2:0] op, input [2:0] s, input [3:0] d);
    cm = {d, 1'b0, s, 1'b0, op};
  endfunction
  task run(input [7:0] so, input integer sv, input [11:0] c, input [7:0] dof, input integer ex);
    begin
      wr(so, sv);
      wr(8'h00, {20'h0, c});
      rdw(dof);
      chk("result", rd, ex & 32'h7fff);
    end
  endtask
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdw(8'h04);
    chk("pc_reset", rd, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      k = i % 3;
      v = (i == 5) ? 32'h7fff : $random(seed) & 32'h7fff;
      run(8'h04 + 4 * k, v, cm(1, k, 2 + k), 8'h04 + 4 * k, v + 1);
      run(8'h04 + 4 * k, v, cm(2, k, 2 + k), 8'h04 + 4 * k, v - 1);
    end
    $display("increment and decrement done");
    for (i = 0; i < 8; i = i + 1) begin
      k = i % 3;
      t = (i % 4 == 0) ? 0 : 1 << k;
      v = $random(seed) & 32'h7fff;
      x = (i == 1) ? 32'h7fff : $random(seed) & 32'h7fff;
      wr(8'h20 + 4 * k, x);
      wr(8'h1c, t);
      run(8'h04, v, cm(0, 0, 3), 8'h08, t ? v - x : v);
    end
    wr(8'h20, x);
    wr(8'h1c, 1);
    run(8'h04, v, cm(4, 0, 1), 8'h20, v - x);
    $display("address modification done");
    for (k = 0; k < 3; k = k + 1) begin
      v = $random(seed) & 32'h7fff;
      run(8'h04, v, cm(3, 0, 5 + k), k == 2 ? 8'h18 : 8'h14 - 4 * k, v);
    end
    x = v;
    v = $random(seed) & 32'h7fff;
    run(8'h04, v, cm(5, 0, 3), 8'h08, v + x);
    run(8'h04, v, cm(1, 0, 8), 8'h38, v + 1);
    chk("switch", seen, (v + 1) & 32'h7fff);
    $display("pass, convert and overlap done");
    for (k = 0; k < 4; k = k + 1) begin
      v = ($random(seed) | 32'h1fff) & 32'h7fff;
      x = (k == 1) ? 32'h3fff : (k == 3) ? 32'h1fff : 32'h7fff;
      wr(8'h2c, k);
      run(8'h04, v, cm(1, 0, 2), 8'h04, (v + 1) & x);
    end
    wr(8'h2c, 0);
    $display("compatibility modes done");
    wr(8'h30, 32'h1);
    chk("stat_write", rs, 2'h2);
    rdw(8'h3c);
    chk("unmapped", rs, 2'h2);
    $display("refusals done");
    print_verdict;
  end
endmodule // ixa_index_adder_test
